// ==== hdl/fault_input_sync.sv ====
// three-stage synchroniser with agreement filter for fault lines
// assumes inputs are asynchronous to i_clk
`timescale 1ns/10ps
module fault_input_sync
  import selftest_fault_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          o_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule : fault_input_sync

// ==== hdl/selftest_fault_pkg.sv ====
// constants for the analog self-test fault status registers
// assumes one system clock; fault lines arrive from analog comparators
package selftest_fault_pkg;

  localparam int REG_WIDTH = 8;
  localparam int SYNC_STAGES = 3;

  // over-voltage result register field positions
  localparam int OV_INTERNAL_REG_BIT = 7;
  localparam int OV_EXT_MON_TWO_BIT = 5;
  localparam int OV_EXT_MON_ONE_BIT = 4;
  localparam int OV_STEPUP_BIT = 3;
  localparam int OV_SECOND_STEPDOWN_BIT = 1;
  localparam int OV_FIRST_STEPDOWN_BIT = 0;

  // current-limit / protection register field positions
  localparam int CL_STEPUP_BIT = 7;
  localparam int CL_SECOND_STEPDOWN_BIT = 5;
  localparam int CL_FIRST_STEPDOWN_BIT = 4;
  localparam int OVP_STEPUP_BIT = 3;
  localparam int OVP_SECOND_STEPDOWN_BIT = 1;
  localparam int OVP_FIRST_STEPDOWN_BIT = 0;

  // implemented bits; reserved bits are zero here
  localparam logic [7:0] OV_VALID_MASK = 8'hbb;
  localparam logic [7:0] CL_VALID_MASK = 8'hbb;

  // reset values
  localparam logic [7:0] OV_RESET = 8'h00;
  localparam logic [7:0] CL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : selftest_fault_pkg

// ==== hdl/selftest_fault_status_regs.sv ====
// analog self-test fault status registers with clear-on-read
// assumes read and write command strobes come from spi logic on I_SYS_CLK
// assumes fault levels arrive unsynchronised from analog comparators
//
// Contract
// - a detected comparator fault sets its bit, latched until the register is read
// - a read clears a set bit only if its fault is gone
// - power-on reset returns both registers to initial state; a clearing read returns only the register read
// - only dedicated read commands reach registers; writes never alter them
// - error bits read 0 for no error, 1 for error, 0 after reset
// - over-voltage bits 5 and 4 report external monitors two and one
// - over-voltage bits 3, 1, 0 report step-up, second, first step-down
// - bits 7, 5, 4 report current-limit faults: step-up, second, first
// - bits 3, 1, 0 report protection faults: step-up, second, first
// - over-voltage bit 7 reports internal regulator; bit 6 reserved zero
`timescale 1ns/10ps
module selftest_fault_status_regs
  import selftest_fault_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_INTERNAL_REG_OVERVOLT_TEST_FAIL,
  input wire logic I_EXT_MONITOR_TWO_OVERVOLT_TEST_FAIL,
  input wire logic I_EXT_MONITOR_ONE_OVERVOLT_TEST_FAIL,
  input wire logic I_STEPUP_OVERVOLT_TEST_FAIL,
  input wire logic I_SECOND_STEPDOWN_OVERVOLT_TEST_FAIL,
  input wire logic I_FIRST_STEPDOWN_OVERVOLT_TEST_FAIL,
  input wire logic I_STEPUP_CURRLIMIT_TEST_FAIL,
  input wire logic I_SECOND_STEPDOWN_CURRLIMIT_TEST_FAIL,
  input wire logic I_FIRST_STEPDOWN_CURRLIMIT_TEST_FAIL,
  input wire logic I_STEPUP_OVERPROTECT_TEST_FAIL,
  input wire logic I_SECOND_STEPDOWN_OVERPROTECT_TEST_FAIL,
  input wire logic I_FIRST_STEPDOWN_OVERPROTECT_TEST_FAIL,
  input wire logic I_READ_OVERVOLT_RESULT_CMD,
  input wire logic I_READ_CURRLIMIT_RESULT_CMD,
  input wire logic I_WRITE_CMD,
  output logic [7:0] O_RDATA,
  output logic O_RDATA_VALID,
  output logic O_CMD_ERR,
  output logic [7:0] O_OVERVOLT_RESULT,
  output logic [7:0] O_CURRLIMIT_RESULT
);

  ////////////////////////////////////////////////////////////////////////////
  // fault inputs gathered into register layout

  logic [7:0] raw_ov;
  logic [7:0] raw_cl;
  logic [7:0] cond_ov;
  logic [7:0] cond_cl;

  always_comb begin
    raw_ov = 8'h00;
    raw_ov[OV_INTERNAL_REG_BIT] = I_INTERNAL_REG_OVERVOLT_TEST_FAIL;
    raw_ov[OV_EXT_MON_TWO_BIT] = I_EXT_MONITOR_TWO_OVERVOLT_TEST_FAIL;
    raw_ov[OV_EXT_MON_ONE_BIT] = I_EXT_MONITOR_ONE_OVERVOLT_TEST_FAIL;
    raw_ov[OV_STEPUP_BIT] = I_STEPUP_OVERVOLT_TEST_FAIL;
    raw_ov[OV_SECOND_STEPDOWN_BIT] = I_SECOND_STEPDOWN_OVERVOLT_TEST_FAIL;
    raw_ov[OV_FIRST_STEPDOWN_BIT] = I_FIRST_STEPDOWN_OVERVOLT_TEST_FAIL;
  end

  always_comb begin
    raw_cl = 8'h00;
    raw_cl[CL_STEPUP_BIT] = I_STEPUP_CURRLIMIT_TEST_FAIL;
    raw_cl[CL_SECOND_STEPDOWN_BIT] = I_SECOND_STEPDOWN_CURRLIMIT_TEST_FAIL;
    raw_cl[CL_FIRST_STEPDOWN_BIT] = I_FIRST_STEPDOWN_CURRLIMIT_TEST_FAIL;
    raw_cl[OVP_STEPUP_BIT] = I_STEPUP_OVERPROTECT_TEST_FAIL;
    raw_cl[OVP_SECOND_STEPDOWN_BIT] =
      I_SECOND_STEPDOWN_OVERPROTECT_TEST_FAIL;
    raw_cl[OVP_FIRST_STEPDOWN_BIT] =
      I_FIRST_STEPDOWN_OVERPROTECT_TEST_FAIL;
  end

  fault_input_sync #(
    .WIDTH(REG_WIDTH)
  ) u_sync_ov (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_async(raw_ov),
    .o_level(cond_ov)
  );

  fault_input_sync #(
    .WIDTH(REG_WIDTH)
  ) u_sync_cl (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_async(raw_cl),
    .o_level(cond_cl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode; over-voltage read wins when both strobes arrive

  logic rd_ov;
  logic rd_cl;
  logic rd_both;
  logic rd_any;

  assign rd_ov = I_READ_OVERVOLT_RESULT_CMD;
  assign rd_cl = I_READ_CURRLIMIT_RESULT_CMD & ~I_READ_OVERVOLT_RESULT_CMD;
  assign rd_both = I_READ_OVERVOLT_RESULT_CMD & I_READ_CURRLIMIT_RESULT_CMD;
  assign rd_any = rd_ov | rd_cl;

  ////////////////////////////////////////////////////////////////////////////
  // latched status bits

  logic [7:0] latch_ov;
  logic [7:0] latch_cl;
  logic [7:0] clr_ov;
  logic [7:0] clr_cl;
  logic [7:0] next_ov;
  logic [7:0] next_cl;

  // bits that a read may drop: held now and no longer flagged
  function automatic logic [7:0] clear_mask(
    input logic [7:0] held,
    input logic [7:0] cond,
    input logic rd
  );
    logic [7:0] gone;
    gone = held & ~cond;
    return rd ? gone : 8'h00;
  endfunction : clear_mask

  // a fault flagged in the read cycle keeps its bit: set wins
  function automatic logic [7:0] next_status(
    input logic [7:0] held,
    input logic [7:0] cond,
    input logic [7:0] clr,
    input logic [7:0] mask
  );
    logic [7:0] kept;
    kept = held & ~clr;
    return (cond | kept) & mask;
  endfunction : next_status

  assign clr_ov = clear_mask(latch_ov, cond_ov, rd_ov);
  assign clr_cl = clear_mask(latch_cl, cond_cl, rd_cl);
  assign next_ov = next_status(latch_ov, cond_ov, clr_ov, OV_VALID_MASK);
  assign next_cl = next_status(latch_cl, cond_cl, clr_cl, CL_VALID_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // status registers; writes have no path into them

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      latch_ov <= OV_RESET;
    end else begin
      latch_ov <= next_ov;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      latch_cl <= CL_RESET;
    end else begin
      latch_cl <= next_cl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data returns the value held before the clear

  logic [7:0] rd_word;

  always_comb begin
    rd_word = latch_cl;
    if (rd_ov) begin
      rd_word = latch_ov;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= RDATA_RESET;
    end else if (rd_any) begin
      O_RDATA <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer strobe, one cycle after the read is taken

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA_VALID <= 1'b0;
    end else begin
      O_RDATA_VALID <= rd_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flagged requests: a write, or two reads at once

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CMD_ERR <= 1'b0;
    end else begin
      O_CMD_ERR <= I_WRITE_CMD | rd_both;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live view of the latched state

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_OVERVOLT_RESULT <= OV_RESET;
    end else begin
      O_OVERVOLT_RESULT <= next_ov;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CURRLIMIT_RESULT <= CL_RESET;
    end else begin
      O_CURRLIMIT_RESULT <= next_cl;
    end
  end

endmodule : selftest_fault_status_regs

// ==== test/selftest_fault_status_regs_assertions.sv ====
// port checker for the fault status registers
// assumes binding onto the register block
`timescale 1ns/10ps
module fault_status_checker (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_STEPUP_OVERVOLT_TEST_FAIL,
  input wire logic I_READ_OVERVOLT_RESULT_CMD,
  input wire logic I_READ_CURRLIMIT_RESULT_CMD,
  input wire logic I_WRITE_CMD,
  input wire logic [7:0] O_RDATA,
  input wire logic O_RDATA_VALID,
  input wire logic O_CMD_ERR,
  input wire logic [7:0] O_OVERVOLT_RESULT,
  input wire logic [7:0] O_CURRLIMIT_RESULT
);
  wire ro = I_READ_OVERVOLT_RESULT_CMD;
  wire rc = I_READ_CURRLIMIT_RESULT_CMD;
  wire [7:0] ov = O_OVERVOLT_RESULT;
  wire [7:0] cl = O_CURRLIMIT_RESULT;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence up_held; I_STEPUP_OVERVOLT_TEST_FAIL [*5]; endsequence
  a_read_valid: assert property ((ro || rc) |=> O_RDATA_VALID)
    else $error("no valid");
  a_write_flag: assert property (I_WRITE_CMD |=> O_CMD_ERR)
    else $error("no cmd err");
  a_ov_return: assert property (ro |=> O_RDATA == $past(ov))
    else $error("ov data");
  a_cl_return: assert property (rc && !ro |=> O_RDATA == $past(cl))
    else $error("cl data");
  a_ov_sticky: assert property (!ro |=> ($past(ov) & ~ov) == 8'h00)
    else $error("ov bit dropped");
  a_reserved_zero: assert property (((ov | cl) & 8'h44) == 8'h00)
    else $error("reserved bit set");
  a_fault_sets: assert property (up_held |=> ov[3])
    else $error("fault not latched");
  a_set_wins: assert property (up_held ##0 ro |=> ov[3])
    else $error("fault cleared");
  a_dual_flag: assert property ((ro && rc) |=> O_CMD_ERR)
    else $error("no cmd err on dual read");
  a_no_err: assert property (!I_WRITE_CMD && !(ro && rc) |=> !O_CMD_ERR)
    else $error("false cmd err");
  a_cl_sticky: assert property ((ro || !rc) |=>
    ($past(cl) & ~cl) == 8'h00) else $error("cl bit dropped");
endmodule : fault_status_checker

bind selftest_fault_status_regs fault_status_checker chk (
  .I_SYS_CLK(I_SYS_CLK),
  .I_RST(I_RST),
  .I_STEPUP_OVERVOLT_TEST_FAIL(I_STEPUP_OVERVOLT_TEST_FAIL),
  .I_READ_OVERVOLT_RESULT_CMD(I_READ_OVERVOLT_RESULT_CMD),
  .I_READ_CURRLIMIT_RESULT_CMD(I_READ_CURRLIMIT_RESULT_CMD),
  .I_WRITE_CMD(I_WRITE_CMD),
  .O_RDATA(O_RDATA),
  .O_RDATA_VALID(O_RDATA_VALID),
  .O_CMD_ERR(O_CMD_ERR),
  .O_OVERVOLT_RESULT(O_OVERVOLT_RESULT),
  .O_CURRLIMIT_RESULT(O_CURRLIMIT_RESULT)
);

// ==== test/selftest_fault_status_regs_tb.sv ====
// self-checking bench for the fault status registers
// assumes host model and checker compiled first
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin \
  err_count++; $display("wrong value %s exp %h got %h", nm, ex, ac); end end
module selftest_fault_status_regs_tb
  import selftest_fault_pkg::*;
;
  logic I_SYS_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [11:0] f = 12'h000;
  wire I_READ_OVERVOLT_RESULT_CMD, I_READ_CURRLIMIT_RESULT_CMD, I_WRITE_CMD;
  wire [7:0] O_RDATA, O_OVERVOLT_RESULT, O_CURRLIMIT_RESULT;
  wire O_RDATA_VALID, O_CMD_ERR;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] d;
  int pos [12] = '{7, 5, 4, 3, 1, 0, 7, 5, 4, 3, 1, 0};
  always #50 I_SYS_CLK = ~I_SYS_CLK;
  selftest_fault_status_regs dut (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST(I_RST),
    .I_READ_OVERVOLT_RESULT_CMD(I_READ_OVERVOLT_RESULT_CMD),
    .I_READ_CURRLIMIT_RESULT_CMD(I_READ_CURRLIMIT_RESULT_CMD),
    .I_WRITE_CMD(I_WRITE_CMD),
    .O_RDATA(O_RDATA),
    .O_RDATA_VALID(O_RDATA_VALID),
    .O_CMD_ERR(O_CMD_ERR),
    .O_OVERVOLT_RESULT(O_OVERVOLT_RESULT),
    .O_CURRLIMIT_RESULT(O_CURRLIMIT_RESULT),
    .I_INTERNAL_REG_OVERVOLT_TEST_FAIL(f[0]),
    .I_EXT_MONITOR_TWO_OVERVOLT_TEST_FAIL(f[1]),
    .I_EXT_MONITOR_ONE_OVERVOLT_TEST_FAIL(f[2]),
    .I_STEPUP_OVERVOLT_TEST_FAIL(f[3]),
    .I_SECOND_STEPDOWN_OVERVOLT_TEST_FAIL(f[4]),
    .I_FIRST_STEPDOWN_OVERVOLT_TEST_FAIL(f[5]),
    .I_STEPUP_CURRLIMIT_TEST_FAIL(f[6]),
    .I_SECOND_STEPDOWN_CURRLIMIT_TEST_FAIL(f[7]),
    .I_FIRST_STEPDOWN_CURRLIMIT_TEST_FAIL(f[8]),
    .I_STEPUP_OVERPROTECT_TEST_FAIL(f[9]),
    .I_SECOND_STEPDOWN_OVERPROTECT_TEST_FAIL(f[10]),
    .I_FIRST_STEPDOWN_OVERPROTECT_TEST_FAIL(f[11]));
  spi_host_model host (.i_clk(I_SYS_CLK), .i_rdata(O_RDATA),
    .i_valid(O_RDATA_VALID), .o_rd_ov(I_READ_OVERVOLT_RESULT_CMD),
    .o_rd_cl(I_READ_CURRLIMIT_RESULT_CMD), .o_wr(I_WRITE_CMD));
  task automatic rd(input int cmd, input logic [7:0] ex);
    host.issue(cmd, d);
    `CHK("read data", ex, d)
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge I_SYS_CLK);
  endtask : tick
  task automatic t_map;
    logic [7:0] ex;
    for (int i = 0; i < 12; i++) begin
      ex = 8'h01 << pos[i];
      @(posedge I_SYS_CLK) f <= 12'h001 << i;
      tick(6);
      f <= 12'h000;
      tick(6);
      rd(0, i < 6 ? ex : 8'h00);
      rd(1, i < 6 ? 8'h00 : ex);
      rd(0, 8'h00);
      rd(1, 8'h00);
    end
    $display("map test done");
  endtask : t_map
  task automatic t_persist;
    @(posedge I_SYS_CLK) f <= 12'hfff;
    tick(6);
    `CHK("ov live", OV_VALID_MASK, O_OVERVOLT_RESULT)
    `CHK("cl live", CL_VALID_MASK, O_CURRLIMIT_RESULT)
    rd(0, OV_VALID_MASK);
    rd(0, OV_VALID_MASK);
    host.issue(2, d);
    `CHK("cmd err", 1'b1, O_CMD_ERR)
    @(posedge I_SYS_CLK) f <= 12'h000;
    tick(6);
    rd(1, CL_VALID_MASK);
    rd(1, 8'h00);
    $display("persist test done");
  endtask : t_persist
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic t_reset;
    rd(0, OV_RESET);
    rd(1, CL_RESET);
    $display("reset test done");
  endtask : t_reset
  task automatic t_dual;
    @(posedge I_SYS_CLK) f <= 12'h041;
    tick(6);
    f <= 12'h000;
    tick(6);
    host.issue(3, d);
    `CHK("dual data", 8'h80, d)
    `CHK("dual err", 1'b1, O_CMD_ERR)
    `CHK("cl kept", 8'h80, O_CURRLIMIT_RESULT)
    rd(0, 8'h00);
    `CHK("read err", 1'b0, O_CMD_ERR)
    rd(1, 8'h80);
    rd(1, 8'h00);
    $display("dual read test done");
  endtask : t_dual
  task automatic t_midreset;
    @(posedge I_SYS_CLK) I_RST <= 1'b1;
    @(posedge I_SYS_CLK) I_RST <= 1'b0;
    rd(0, OV_RESET);
    $display("mid-run reset test done");
  endtask : t_midreset
  initial begin
    tick(16);
    I_RST <= 1'b0;
    t_reset;
    t_map;
    t_dual;
    t_persist;
    t_midreset;
    complete_run;
  end
  initial begin
    #2000000;
    err_count++;
    complete_run;
  end
endmodule : selftest_fault_status_regs_tb

// ==== test/spi_host_model.sv ====
// spi controller model issuing one-cycle command strobes
// assumes strobes are taken on the rising edge
`timescale 1ns/10ps
module spi_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_valid,
  output logic o_rd_ov = 1'b0,
  output logic o_rd_cl = 1'b0,
  output logic o_wr = 1'b0
);
  // cmd 0 reads over-voltage, 1 current-limit, 2 writes, 3 both reads
  task automatic issue(input int cmd, output logic [7:0] d);
    @(posedge i_clk);
    o_rd_ov <= cmd == 0 || cmd == 3;
    o_rd_cl <= cmd == 1 || cmd == 3;
    o_wr <= cmd == 2;
    @(posedge i_clk);
    {o_rd_ov, o_rd_cl, o_wr} <= 3'h0;
    // answer taken at the edge where valid is sampled high
    @(posedge i_clk);
    d = i_valid ? i_rdata : 8'hxx;
  endtask : issue
endmodule : spi_host_model
